// ### rtl/unb_regs.svh
// Register offsets, fields, reset values and bit-timing counts for the nine-bit UART
`ifndef UNB_REGS_SVH
`define UNB_REGS_SVH
`define UNB_OFF_DATA 8'h00
`define UNB_OFF_STAT 8'h04
`define UNB_OFF_CTRL 8'h08
`define UNB_OFF_BAUD 8'h0c
`define UNB_OFF_ADDR 8'h10
`define UNB_OFF_ASND 8'h14
`define UNB_C_WLEN 1:0
`define UNB_C_PAR 3:2
`define UNB_C_STICK 4
`define UNB_C_TWO 5
`define UNB_C_BRK 6
`define UNB_C_NINE 7
`define UNB_C_OSC 8
`define UNB_CTRL_W 9
`define UNB_CTRL_RST 9'h003
`define UNB_BAUD_RST 16'h0001
`define UNB_NADR_RST 8'h00
`define UNB_NMSK_RST 8'hff
`define UNB_SUB_LAST 4'hf
`define UNB_SUB_MID 4'h7
`define UNB_MIN_WLEN 4'h5
`define UNB_LINE_IDLE 1'b1
`endif

// ### rtl/unb_pkg.sv
// Types shared by the nine-bit UART
package unb_pkg;
  typedef enum logic [1:0] {
    UNB_RX_IDLE = 2'b00,
    UNB_RX_START = 2'b01,
    UNB_RX_BITS = 2'b10,
    UNB_RX_HOLD = 2'b11
  } unb_rx_e;
  typedef enum logic [1:0] {
    UNB_PAR_NONE = 2'b00,
    UNB_PAR_EVEN = 2'b01,
    UNB_PAR_ODD = 2'b10,
    UNB_PAR_STICK = 2'b11
  } unb_par_e;
  typedef logic [31:0] unb_word_t;
endpackage

// ### rtl/unb_uart.sv
// Nine-bit addressable UART with AHB-Lite register slave
`timescale 1ns/10ps
`include "unb_regs.svh"
module unb_uart #(
  parameter int DEPTH = 16
) (
  input wire logic sys_clk, // 125 MHz system clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire unb_pkg::unb_word_t haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Word transfers only
  input wire unb_pkg::unb_word_t hwdata, // Write data
  input wire logic hready, // Bus ready
  output unb_pkg::unb_word_t hrdata, // Read data
  output logic hreadyout, // Low while a write waits for queue space
  output logic hresp, // Always OKAY
  input wire logic osc_tick, // One pulse per internal oscillator period
  input wire logic rxd, // Serial input
  output logic txd // Serial output
);
  import unb_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] tmem;
    logic [AW-1:0] twp;
    logic [AW-1:0] trp;
    logic [AW:0] tcnt;
    logic [DEPTH-1:0][11:0] rmem;
    logic [AW-1:0] rwp;
    logic [AW-1:0] rrp;
    logic [AW:0] rcnt;
    logic [`UNB_CTRL_W-1:0] ctrl;
    logic [15:0] div;
    logic [7:0] nadr;
    logic [7:0] nmsk;
    logic apend;
    logic [7:0] abyte;
    logic [15:0] bcnt;
    logic [3:0] tsub;
    logic [11:0] tsh;
    logic [3:0] tleft;
    logic txo;
    unb_rx_e rst;
    logic [3:0] rsub;
    logic [9:0] rsh;
    logic [3:0] rgot;
    logic rsel;
    logic rovr;
    logic dph;
    logic dwr;
    logic [7:0] dadr;
    unb_word_t rdat;
  } unb_state_s;

  unb_state_s s_reg;
  unb_state_s s_next;
  logic tick, ap, stall, busy, tload, tpop, tpush, rpush, rpop, rdone;
  logic xon, xb, rxb, isaddr, ferr, perr, brk, store;
  logic [3:0] nb, rk, tlen;
  logic [7:0] dmask, tdat, rd;
  logic [11:0] fr;
  logic [9:0] al;
  unb_par_e par;

  assign hresp = 1'b0;
  assign hrdata = s_reg.rdat;
  assign txd = s_reg.txo;
  // A data write into a full queue holds the bus rather than dropping the character
  assign stall = s_reg.dph && s_reg.dwr && s_reg.dadr == `UNB_OFF_DATA && s_reg.tcnt == FULL;
  assign hreadyout = !stall;
  assign busy = s_reg.tcnt != '0 || s_reg.apend || s_reg.tleft != 4'h0;

  // Next-state logic for bus slave, baud divider, transmitter and receiver
  always_comb begin
    s_next = s_reg;
    par = unb_par_e'(s_reg.ctrl[`UNB_C_PAR]);
    nb = `UNB_MIN_WLEN + {2'h0, s_reg.ctrl[`UNB_C_WLEN]};
    dmask = 8'hff >> (4'h8 - nb);
    // Ninth bit takes the parity slot, so nine-bit frames carry no parity
    xon = s_reg.ctrl[`UNB_C_NINE] || par != UNB_PAR_NONE;
    // Baud divider: divisor zero stops the line, divisor N gives source/(16N)
    tick = 1'b0;
    if (s_reg.div != 16'h0 && (!s_reg.ctrl[`UNB_C_OSC] || osc_tick)) begin
      if (s_reg.bcnt >= s_reg.div - 16'h1) begin
        s_next.bcnt = 16'h0;
        tick = 1'b1;
      end else begin
        s_next.bcnt = s_reg.bcnt + 16'h1;
      end
    end
    // Transmitter: address holding slot has priority over the queue
    tload = s_reg.tleft == 4'h0 && !s_reg.ctrl[`UNB_C_BRK] && (s_reg.apend || s_reg.tcnt != '0);
    isaddr = s_reg.apend;
    tpop = tload && !s_reg.apend;
    tdat = s_reg.apend ? s_reg.abyte : s_reg.tmem[s_reg.trp];
    case (par)
      UNB_PAR_EVEN: xb = ^(tdat & dmask);
      UNB_PAR_ODD: xb = ~^(tdat & dmask);
      default: xb = s_reg.ctrl[`UNB_C_STICK];
    endcase
    if (s_reg.ctrl[`UNB_C_NINE]) begin
      xb = isaddr;
    end
    fr = 12'hffe;
    fr[8:1] = tdat | ~dmask;
    if (xon) begin
      fr[nb + 4'h1] = xb;
    end
    tlen = 4'h2 + nb + {3'h0, xon} + {3'h0, s_reg.ctrl[`UNB_C_TWO]};
    if (tload) begin
      s_next.tsh = fr;
      s_next.tleft = tlen;
      s_next.tsub = 4'h0;
      s_next.apend = 1'b0;
    end else if (tick && s_reg.tleft != 4'h0) begin
      s_next.tsub = s_reg.tsub + 4'h1;
      if (s_reg.tsub == `UNB_SUB_LAST) begin
        s_next.tsh = {1'b1, s_reg.tsh[11:1]};
        s_next.tleft = s_reg.tleft - 4'h1;
      end
    end
    if (tpop) begin
      s_next.trp = s_reg.trp + 1'b1;
    end
    // Break overrides whatever the shifter holds
    s_next.txo = s_reg.ctrl[`UNB_C_BRK] ? 1'b0 : (s_next.tleft != 4'h0 ? s_next.tsh[0] : 1'b1);
    // Receiver: sample mid-bit on the 16x tick
    rk = nb + {3'h0, xon} + 4'h1;
    rdone = 1'b0;
    if (tick) begin
      case (s_reg.rst)
        UNB_RX_IDLE: begin
          if (!rxd) begin
            s_next.rst = UNB_RX_START;
            s_next.rsub = 4'h0;
          end
        end
        UNB_RX_START: begin
          s_next.rsub = s_reg.rsub + 4'h1;
          if (s_reg.rsub == `UNB_SUB_MID) begin
            s_next.rst = rxd ? UNB_RX_IDLE : UNB_RX_BITS;
            s_next.rsub = 4'h0;
            s_next.rgot = 4'h0;
          end
        end
        UNB_RX_BITS: begin
          s_next.rsub = s_reg.rsub + 4'h1;
          if (s_reg.rsub == `UNB_SUB_LAST) begin
            s_next.rsh = {rxd, s_reg.rsh[9:1]};
            s_next.rgot = s_reg.rgot + 4'h1;
            if (s_reg.rgot + 4'h1 == rk) begin
              rdone = 1'b1;
              s_next.rst = rxd ? UNB_RX_IDLE : UNB_RX_HOLD;
            end
          end
        end
        default: begin
          // Wait for the line to return high after a break or bad stop
          if (rxd) begin
            s_next.rst = UNB_RX_IDLE;
          end
        end
      endcase
    end
    al = s_next.rsh >> (4'ha - rk);
    rd = al[7:0] & dmask;
    rxb = al[nb];
    ferr = !al[rk - 4'h1];
    brk = al == 10'h0;
    case (par)
      UNB_PAR_EVEN: perr = rxb != ^rd;
      UNB_PAR_ODD: perr = rxb != ~^rd;
      UNB_PAR_STICK: perr = rxb != s_reg.ctrl[`UNB_C_STICK];
      default: perr = 1'b0;
    endcase
    if (s_reg.ctrl[`UNB_C_NINE]) begin
      perr = 1'b0;
    end
    store = 1'b1;
    if (s_reg.ctrl[`UNB_C_NINE]) begin
      if (rxb) begin
        store = (rd & s_reg.nmsk) == s_reg.nadr;
        if (rdone) begin
          s_next.rsel = store;
        end
      end else begin
        store = s_reg.rsel;
      end
    end
    // Bus address phase; reads are answered from flops in the next cycle
    ap = hsel && hready && htrans[1];
    rpop = 1'b0;
    if (ap && !hwrite) begin
      s_next.rdat = 32'h0;
      if (haddr[7:0] == `UNB_OFF_DATA) begin
        if (s_reg.rcnt != '0) begin
          s_next.rdat = {20'h0, s_reg.rmem[s_reg.rrp]};
          rpop = 1'b1;
        end
      end else if (haddr[7:0] == `UNB_OFF_STAT) begin
        s_next.rdat = {27'h0, s_reg.rcnt == FULL, s_reg.rcnt == '0, s_reg.tcnt == '0,
                       s_reg.tcnt == FULL, busy};
      end else if (haddr[7:0] == `UNB_OFF_CTRL) begin
        s_next.rdat = {23'h0, s_reg.ctrl};
      end else if (haddr[7:0] == `UNB_OFF_BAUD) begin
        s_next.rdat = {16'h0, s_reg.div};
      end else if (haddr[7:0] == `UNB_OFF_ADDR) begin
        s_next.rdat = {16'h0, s_reg.nmsk, s_reg.nadr};
      end else if (haddr[7:0] == `UNB_OFF_ASND) begin
        s_next.rdat = {31'h0, s_reg.apend};
      end
    end
    if (!stall) begin
      s_next.dph = ap;
      s_next.dwr = hwrite;
      s_next.dadr = haddr[7:0];
    end
    // Data phase writes
    tpush = 1'b0;
    if (s_reg.dph && s_reg.dwr && !stall) begin
      if (s_reg.dadr == `UNB_OFF_DATA) begin
        tpush = 1'b1;
      end else if (s_reg.dadr == `UNB_OFF_CTRL) begin
        s_next.ctrl = hwdata[`UNB_CTRL_W-1:0];
      end else if (s_reg.dadr == `UNB_OFF_BAUD) begin
        s_next.div = hwdata[15:0];
      end else if (s_reg.dadr == `UNB_OFF_ADDR) begin
        s_next.nadr = hwdata[7:0];
        s_next.nmsk = hwdata[15:8];
      end else if (s_reg.dadr == `UNB_OFF_ASND) begin
        s_next.apend = 1'b1;
        s_next.abyte = hwdata[7:0];
      end
    end
    if (tpush) begin
      s_next.tmem[s_reg.twp] = hwdata[7:0];
      s_next.twp = s_reg.twp + 1'b1;
    end
    s_next.tcnt = s_reg.tcnt + {{AW{1'b0}}, tpush} - {{AW{1'b0}}, tpop};
    // Receive queue; overrun rides on the next character that fits
    rpush = 1'b0;
    if (rdone && store) begin
      if (s_reg.rcnt == FULL && !rpop) begin
        s_next.rovr = 1'b1;
      end else begin
        rpush = 1'b1;
        s_next.rmem[s_reg.rwp] = {s_reg.rovr, brk, perr, ferr, rd};
        s_next.rwp = s_reg.rwp + 1'b1;
        s_next.rovr = 1'b0;
      end
    end
    if (rpop) begin
      s_next.rrp = s_reg.rrp + 1'b1;
    end
    s_next.rcnt = s_reg.rcnt + {{AW{1'b0}}, rpush} - {{AW{1'b0}}, rpop};
  end

  // State register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.ctrl <= `UNB_CTRL_RST;
      s_reg.div <= `UNB_BAUD_RST;
      s_reg.nadr <= `UNB_NADR_RST;
      s_reg.nmsk <= `UNB_NMSK_RST;
      s_reg.tsh <= 12'hfff;
      s_reg.txo <= `UNB_LINE_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_busy_drain: assert property (!busy |-> s_reg.tcnt == '0 && s_reg.tleft == 4'h0)
    else $error("busy low with work pending");
  chk_idle_line: assert property (!busy && !s_reg.ctrl[`UNB_C_BRK] |=> txd)
    else $error("line not idle high");
  chk_break_out: assert property (s_reg.ctrl[`UNB_C_BRK] |=> !txd)
    else $error("break not driven");
  chk_start_bit: assert property (tload |=> !txd ##0 s_reg.tleft == $past(tlen))
    else $error("frame did not open with start bit");
  chk_two_stop: assert property (tload && s_reg.ctrl[`UNB_C_TWO] && nb == 4'h8 && !xon
                  |=> s_reg.tleft == 4'hb)
    else $error("wrong frame length for two stops");
  chk_rx_bound: assert property (s_reg.rcnt <= FULL && s_reg.tcnt <= FULL)
    else $error("queue count exceeds depth");
  chk_addr_filter: assert property (rdone && s_reg.ctrl[`UNB_C_NINE] && !rxb && !s_reg.rsel
                    |-> !rpush)
    else $error("unselected data stored");
  chk_plain_store: assert property (rdone && !s_reg.ctrl[`UNB_C_NINE] && s_reg.rcnt != FULL
                    |=> s_reg.rcnt == $past(s_reg.rcnt) + 1'b1 - $past(rpop))
    else $error("plain frame not stored");
  chk_baud_stop: assert property (s_reg.div == 16'h0 |-> !tick)
    else $error("tick with zero divisor");
  chk_nine_bit: assert property (tload && s_reg.ctrl[`UNB_C_NINE] |-> fr[nb + 4'h1] == isaddr)
    else $error("ninth bit wrong");
  chk_full_stall: assert property (stall |-> !hreadyout ##1 s_reg.tcnt <= FULL)
    else $error("write to full queue not held");
  // Baud source gating, read data holding and frame format
  chk_osc_gate: assert property (s_reg.ctrl[`UNB_C_OSC] && !osc_tick |-> !tick)
    else $error("tick without oscillator pulse");
  chk_rdat_hold: assert property (!(ap && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  chk_frame_len: assert property (tload |-> tlen >= nb + 4'h2 && tlen <= nb + 4'h4)
    else $error("frame length out of range");
  chk_tx_even: assert property (tload && !s_reg.ctrl[`UNB_C_NINE] && par == UNB_PAR_EVEN
                |-> !(^(fr[8:1] & dmask) ^ fr[nb + 4'h1]))
    else $error("even parity bit wrong");
  chk_nine_noperr: assert property (rdone && s_reg.ctrl[`UNB_C_NINE] |-> !perr)
    else $error("parity flagged in nine-bit mode");
  cov_break_rx: cover property (rpush && brk);
  cov_addr_hit: cover property (rdone && s_reg.ctrl[`UNB_C_NINE] && rxb && store);
  cov_overrun: cover property (rdone && store && s_reg.rcnt == FULL && !rpop);
  cov_stall_write: cover property (stall ##[1:300] !stall);
  cov_osc_load: cover property (tload && s_reg.ctrl[`UNB_C_OSC]);
endmodule

// ### dv/unb_node.sv
// Remote serial node model: drives frames into the receiver, samples transmitted frames
`timescale 1ns/10ps
module unb_node #(
  parameter int BIT = 16 // Clocks per bit at divisor 1
) (
  input wire logic sys_clk, // System clock
  input wire logic txd, // Line from the device
  output logic rxd // Line into the device
);
  // Released line rests at the mark level
  initial rxd = 1'b1;
  // Sends n bits, first bit first, each standing one bit time
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge sys_clk);
    end
    rxd <= 1'b1;
  endtask
  // Level wait tolerates a start bit that began a few clocks early
  task automatic grab(input int n, output logic [11:0] f);
    f = '1;
    wait (txd === 1'b0);
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (BIT) @(posedge sys_clk);
    end
  endtask
endmodule

// ### dv/tb.sv
// Testbench for the nine-bit UART: bus tasks, frame builder and scenarios
`timescale 1ns/10ps
`include "unb_regs.svh"
module tb;
  import unb_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  unb_word_t haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  unb_word_t hwdata = '0;
  unb_word_t hrdata, rd, rd_s;
  logic hreadyout, hresp, txd, rxd, rdy_s;
  logic osc_tick = 1'b0;
  logic [11:0] fr, got;
  int n;
  int error_cnt = 0;
  int checks_done = 0;
  always #4 sys_clk = ~sys_clk;
  // Oscillator stand-in
  always @(posedge sys_clk) osc_tick <= ~osc_tick;
  // Copies taken mid-cycle so the edge sample never races the design
  always @(negedge sys_clk) begin
    rdy_s = hreadyout;
    rd_s = hrdata;
  end
  unb_uart unb_uart_i (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_tick(osc_tick),
    .rxd(rxd), .txd(txd));
  unb_node unb_node_i (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Single word transfer; each phase is held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input unb_word_t d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (rdy_s !== 1'b1);
    rd = rd_s;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input unb_word_t d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input unb_word_t e);
    bus(1'b0, a, '0);
    chk(nm, rd, e);
  endtask
  // Polls until the transmitter reports idle, bounded
  task automatic idle();
    for (int i = 0; i < 600; i++) begin
      bus(1'b0, `UNB_OFF_STAT, '0);
      if (rd[0] === 1'b0) return;
      repeat (8) @(posedge sys_clk);
    end
    chk("busy", {31'h0, rd[0]}, 32'h0);
  endtask
  // Expected line bits for one character under control word c
  function automatic int frm(input logic [7:0] d, input logic [8:0] c, input logic nin,
                             output logic [11:0] f);
    int k;
    logic p;
    k = c[1:0] + 5;
    p = ^(d & 8'((9'h1 << k) - 1));
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < k; i++) f[i + 1] = d[i];
    k++;
    if (c[7]) begin
      f[k] = nin;
      k++;
    end else if (c[3:2] != 2'b00) begin
      f[k] = (c[3:2] == 2'b01) ? p : (c[3:2] == 2'b10) ? ~p : c[4];
      k++;
    end
    return k + 1 + c[5];
  endfunction
  // Every character, address or data, goes out on a drained transmitter
  task automatic txchk(input logic [8:0] c, input logic [7:0] d, input logic nin);
    idle();
    wr(`UNB_OFF_CTRL, {23'h0, c});
    n = frm(d, c, nin, fr);
    if (nin) wr(`UNB_OFF_ASND, {24'h0, d});
    else wr(`UNB_OFF_DATA, {24'h0, d});
    unb_node_i.grab(n, got);
    chk("tx frame", {20'h0, got}, {20'h0, fr});
  endtask
  task automatic rxsend(input logic [8:0] c, input logic [7:0] d, input logic nin,
                        input logic [11:0] flip);
    n = frm(d, c, nin, fr);
    unb_node_i.send(fr ^ flip, n);
    repeat (24) @(posedge sys_clk);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rchk("ctrl", `UNB_OFF_CTRL, 32'h003);
    rchk("baud", `UNB_OFF_BAUD, 32'h001);
    rchk("addr", `UNB_OFF_ADDR, 32'hff00);
    rchk("stat", `UNB_OFF_STAT, 32'h00c);
    rchk("hole", 8'h18, 32'h0);
    // Each length, parity kind and stop count on the line
    txchk(9'h003, 8'ha5, 1'b0);
    txchk(9'h000, 8'h1d, 1'b0);
    txchk(9'h025, 8'h35, 1'b0);
    txchk(9'h02a, 8'h6b, 1'b0);
    txchk(9'h023, 8'h96, 1'b0);
    txchk(9'h01f, 8'hc4, 1'b0);
    txchk(9'h00f, 8'hc4, 1'b0);
    wr(`UNB_OFF_DATA, 32'h55);
    rchk("busy set", `UNB_OFF_STAT, 32'h009);
    idle();
    // Receive: clean, short length, parity error, break
    wr(`UNB_OFF_CTRL, 32'h007);
    rxsend(9'h007, 8'h3c, 1'b0, 12'h0);
    rchk("rx data", `UNB_OFF_DATA, 32'h03c);
    rxsend(9'h007, 8'h3c, 1'b0, 12'h200);
    rchk("rx parity", `UNB_OFF_DATA, 32'h23c);
    unb_node_i.send(12'h000, 11);
    repeat (40) @(posedge sys_clk);
    bus(1'b0, `UNB_OFF_DATA, '0);
    chk("rx break", rd & 32'h400, 32'h400);
    rchk("rx empty", `UNB_OFF_DATA, 32'h0);
    wr(`UNB_OFF_CTRL, 32'h000);
    rxsend(9'h000, 8'h15, 1'b0, 12'h0);
    rchk("rx len5", `UNB_OFF_DATA, 32'h015);
    // Multidrop: masked match, miss, exact mask
    wr(`UNB_OFF_CTRL, 32'h083);
    wr(`UNB_OFF_ADDR, 32'hf050);
    rxsend(9'h083, 8'h53, 1'b1, 12'h0);
    rxsend(9'h083, 8'h11, 1'b0, 12'h0);
    rxsend(9'h083, 8'h63, 1'b1, 12'h0);
    rxsend(9'h083, 8'h22, 1'b0, 12'h0);
    rchk("addr hit", `UNB_OFF_DATA, 32'h053);
    rchk("data sel", `UNB_OFF_DATA, 32'h011);
    rchk("dropped", `UNB_OFF_DATA, 32'h0);
    wr(`UNB_OFF_ADDR, 32'hff53);
    rxsend(9'h083, 8'h52, 1'b1, 12'h0);
    rxsend(9'h083, 8'h53, 1'b1, 12'h0);
    rchk("exact", `UNB_OFF_DATA, 32'h053);
    txchk(9'h083, 8'h5a, 1'b1);
    txchk(9'h083, 8'h5a, 1'b0);
    txchk(9'h003, 8'h5a, 1'b0);
    rxsend(9'h003, 8'h22, 1'b0, 12'h0);
    rchk("plain rx", `UNB_OFF_DATA, 32'h022);
    // Oscillator source halves the tick rate, so the frame still runs after 240 clocks
    wr(`UNB_OFF_CTRL, 32'h103);
    wr(`UNB_OFF_DATA, 32'h5a);
    repeat (240) @(posedge sys_clk);
    rchk("osc slow", `UNB_OFF_STAT, 32'h00d);
    idle();
    // Divisor zero freezes the shifter on its start bit until a divisor returns
    wr(`UNB_OFF_BAUD, 32'h0);
    wr(`UNB_OFF_DATA, 32'h5a);
    repeat (200) @(posedge sys_clk);
    rchk("baud off", `UNB_OFF_STAT, 32'h00d);
    chk("frozen line", {31'h0, txd}, 32'h0);
    wr(`UNB_OFF_BAUD, 32'h1);
    idle();
    // Break holds loads, so the queue fills while the line stays low
    wr(`UNB_OFF_CTRL, 32'h043);
    for (int i = 0; i < 16; i++) wr(`UNB_OFF_DATA, 32'(i));
    rchk("tx full", `UNB_OFF_STAT, 32'h00b);
    chk("break line", {31'h0, txd}, 32'h0);
    repeat (400) @(posedge sys_clk);
    wr(`UNB_OFF_CTRL, 32'h003);
    // The second extra character finds the queue full and waits with hready low
    wr(`UNB_OFF_DATA, 32'h7e);
    wr(`UNB_OFF_DATA, 32'h7f);
    idle();
    rchk("drained", `UNB_OFF_STAT, 32'h00c);
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
